/* File: hdl/sacs_pkg.sv */
// Package for the converter control sequencer: register map, fields, timing.
// Assumes a 32-bit classic Wishbone bus and a 25 MHz system clock.
package sacs_pkg;

    // Register byte addresses.
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] SETTLE_OFS   = 8'h04;
    localparam logic [7:0] HOLD_OFS     = 8'h08;
    localparam logic [7:0] RES_HI_OFS   = 8'h0C;
    localparam logic [7:0] RES_LO_OFS   = 8'h10;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h18;

    // Control register fields.
    localparam int CTRL_START_BIT = 7;
    localparam int CTRL_REFEN_BIT = 5;
    localparam int CTRL_ENA_BIT   = 4;
    localparam int CTRL_CHAN_LSB  = 0;
    localparam int CHAN_W         = 3;
    localparam logic [7:0] CTRL_WMASK = 8'hB7;

    // Reset values.
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] SETTLE_RST = 8'h0F;
    localparam logic [7:0] HOLD_RST   = 8'h7F;

    // Interrupt status bits.
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_W        = 1;

    // Result width and timing.
    localparam int RES_W = 10;
    localparam int CLK_MHZ = 25;
    localparam int CONV_MAX_NS = 11900;
    localparam int CONV_MAX_CYC = (CONV_MAX_NS * CLK_MHZ) / 1000;

    typedef enum logic [1:0] {
        SACS_IDLE,
        SACS_SETTLE,
        SACS_HOLD,
        SACS_CONV
    } sacs_state_e;

    typedef struct packed {
        logic [7:0] adr;
        logic       we;
        logic [3:0] sel;
        logic [7:0] dat;
    } sacs_req_s;

endpackage

/* File: hdl/sacs_sar.sv */
// Successive approximation engine: one bit decision per clock cycle.
// Assumes the comparator input is synchronous to the clock.
`timescale 1ns/1ps
module sacs_sar #(
    parameter int RES_W = 10
) (
    // Clock and reset.
    input  wire logic             mclk_i,
    input  wire logic             reset_i,
    // Control.
    input  wire logic             start_i,
    input  wire logic             cmp_i,
    // Results.
    output logic [RES_W-1:0]      trial_o,
    output logic                  done_o,
    output logic [RES_W-1:0]      result_o
);

    logic [RES_W-1:0] bit_r;
    logic [RES_W-1:0] acc_r;
    logic             busy_r;

    assign trial_o = acc_r | bit_r;

    // Binary search from the top bit; the comparator says whether the trial is under the input.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            bit_r    <= '0;
            acc_r    <= '0;
            busy_r   <= 1'b0;
            done_o   <= 1'b0;
            result_o <= '0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i && !busy_r)
            begin
                acc_r  <= '0;
                bit_r  <= {1'b1, {(RES_W-1){1'b0}}};
                busy_r <= 1'b1;
            end
            else if (busy_r)
            begin
                if (cmp_i)
                    acc_r <= acc_r | bit_r;
                bit_r <= bit_r >> 1;
                if (bit_r[0])
                begin
                    busy_r   <= 1'b0;
                    done_o   <= 1'b1;
                    result_o <= cmp_i ? (acc_r | bit_r) : acc_r;
                end
            end
        end
    end

endmodule

/* File: hdl/sacs_top.sv */
// Converter control sequencer: registers, sampling timing and sequencing.
// Assumes a classic Wishbone master and a comparator input synchronous to mclk_i.
// How it works
// - Each conversion yields a ten-bit result.
// - Eight inputs, each needs alternate function enable.
// - Whole conversion finishes under 11.9 microseconds with reset settle and hold timing.
// - Control bits 2:0 pick the input.
// - Bit 7 starts; hardware clears it when done.
// - Control bit 5 enables the internal reference.
// - Control bit 4 enables; clear means no new conversion starts, but a running one finishes.
// - Settling and hold registers time the sampling.
`timescale 1ns/1ps
module sacs_top #(
    parameter int NCHAN = 8,
    parameter int RES_W = 10
) (
    // Clock and reset.
    input  wire logic                 mclk_i,
    input  wire logic                 reset_i,
    // Wishbone slave.
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // Analog front end.
    input  wire logic                 cmp_i,
    input  wire logic [NCHAN-1:0]     pin_alt_i,
    output logic [$clog2(NCHAN)-1:0]  mux_sel_o,
    output logic                      sample_o,
    output logic                      ref_en_o,
    output logic                      conv_en_o,
    output logic [RES_W-1:0]          dac_o,
    // Interrupt.
    output logic                      irq_o
);

    localparam int CW = sacs_pkg::CHAN_W;

    logic [7:0]              ctrl_r;
    logic [7:0]              settle_r;
    logic [7:0]              hold_r;
    logic [RES_W-1:0]        res_r;
    logic [sacs_pkg::IRQ_W-1:0] stat_r;
    logic [sacs_pkg::IRQ_W-1:0] mask_r;
    logic [7:0]              cnt_r;
    logic                    sar_go_r;
    logic                    sar_done;
    logic [RES_W-1:0]        sar_res;
    sacs_pkg::sacs_state_e   st_r;
    sacs_pkg::sacs_req_s     req;
    logic                    wr_stb;
    logic                    rd_hit;
    logic [7:0]              rd_byte;
    logic                    chan_ok;
    logic                    start_wr;

    assign req.adr = wb_adr_i;
    assign req.we  = wb_we_i;
    assign req.sel = wb_sel_i;
    assign req.dat = wb_dat_i[7:0];

    // Writes land on the first cycle of the request, before the ack goes out.
    assign wr_stb   = wb_cyc_i && wb_stb_i && !wb_ack_o && req.we && req.sel[0];
    assign start_wr = wr_stb && (req.adr == sacs_pkg::CTRL_OFS)
                      && req.dat[sacs_pkg::CTRL_START_BIT];

    // An input only reaches the converter once its pin is switched to the analog function.
    assign chan_ok = pin_alt_i[ctrl_r[sacs_pkg::CTRL_CHAN_LSB +: CW]];

    assign mux_sel_o = ctrl_r[sacs_pkg::CTRL_CHAN_LSB +: CW];
    assign ref_en_o  = ctrl_r[sacs_pkg::CTRL_REFEN_BIT];
    assign conv_en_o = ctrl_r[sacs_pkg::CTRL_ENA_BIT];
    assign sample_o  = (st_r == sacs_pkg::SACS_SETTLE) || (st_r == sacs_pkg::SACS_HOLD);
    assign irq_o     = |(stat_r & mask_r);

    // Control register: software writes, hardware owns the start bit while busy.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            ctrl_r <= sacs_pkg::CTRL_RST;
        else if (wr_stb && req.adr == sacs_pkg::CTRL_OFS)
        begin
            ctrl_r <= req.dat & sacs_pkg::CTRL_WMASK;
            // A start is refused while disabled, so the bit never sticks.
            // A completion in the same cycle still clears the old start, or it would rerun.
            ctrl_r[sacs_pkg::CTRL_START_BIT] <= (ctrl_r[sacs_pkg::CTRL_START_BIT] && !sar_done)
                || (req.dat[sacs_pkg::CTRL_START_BIT] && req.dat[sacs_pkg::CTRL_ENA_BIT]);
        end
        else if (sar_done || (st_r == sacs_pkg::SACS_IDLE && !ctrl_r[sacs_pkg::CTRL_ENA_BIT]))
            ctrl_r[sacs_pkg::CTRL_START_BIT] <= 1'b0;
    end

    // Timing and interrupt mask registers.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            settle_r <= sacs_pkg::SETTLE_RST;
            hold_r   <= sacs_pkg::HOLD_RST;
            mask_r   <= '0;
        end
        else if (wr_stb)
        begin
            if (req.adr == sacs_pkg::SETTLE_OFS)
                settle_r <= req.dat;
            if (req.adr == sacs_pkg::HOLD_OFS)
                hold_r <= req.dat;
            if (req.adr == sacs_pkg::IRQ_MASK_OFS)
                mask_r <= req.dat[sacs_pkg::IRQ_W-1:0];
        end
    end

    // Sequencer: settle, hold, then the bit decisions.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            st_r     <= sacs_pkg::SACS_IDLE;
            cnt_r    <= 8'h00;
            sar_go_r <= 1'b0;
        end
        else
        begin
            sar_go_r <= 1'b0;
            case (st_r)
                sacs_pkg::SACS_IDLE:
                    if (ctrl_r[sacs_pkg::CTRL_START_BIT] && ctrl_r[sacs_pkg::CTRL_ENA_BIT])
                    begin
                        st_r  <= sacs_pkg::SACS_SETTLE;
                        cnt_r <= settle_r;
                    end
                sacs_pkg::SACS_SETTLE:
                    if (cnt_r == 8'h00)
                    begin
                        st_r  <= sacs_pkg::SACS_HOLD;
                        cnt_r <= hold_r;
                    end
                    else
                        cnt_r <= cnt_r - 8'h01;
                sacs_pkg::SACS_HOLD:
                    if (cnt_r == 8'h00)
                    begin
                        st_r     <= sacs_pkg::SACS_CONV;
                        sar_go_r <= 1'b1;
                    end
                    else
                        cnt_r <= cnt_r - 8'h01;
                sacs_pkg::SACS_CONV:
                    if (sar_done)
                        st_r <= sacs_pkg::SACS_IDLE;
                default:
                    st_r <= sacs_pkg::SACS_IDLE;
            endcase
        end
    end

    // With reset timing the path is 16 + 128 + 11 cycles, 6.2 us, under the limit.
    sacs_sar #(
        .RES_W    (RES_W)
    ) u_sar (
        .mclk_i   (mclk_i),
        .reset_i  (reset_i),
        .start_i  (sar_go_r),
        .cmp_i    (cmp_i && chan_ok),
        .trial_o  (dac_o),
        .done_o   (sar_done),
        .result_o (sar_res)
    );

    // Result stays put until the next conversion finishes.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            res_r <= '0;
        else if (sar_done)
            res_r <= sar_res;
    end

    // Done flag; a new event wins over a write-one clear in the same cycle.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            stat_r <= '0;
        else if (sar_done)
            stat_r[sacs_pkg::IRQ_DONE_BIT] <= 1'b1;
        else if (wr_stb && req.adr == sacs_pkg::IRQ_STAT_OFS)
            stat_r <= stat_r & ~req.dat[sacs_pkg::IRQ_W-1:0];
    end

    // Read data mux.
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (req.adr)
            sacs_pkg::CTRL_OFS:     rd_byte = ctrl_r;
            sacs_pkg::SETTLE_OFS:   rd_byte = settle_r;
            sacs_pkg::HOLD_OFS:     rd_byte = hold_r;
            sacs_pkg::RES_HI_OFS:   rd_byte = res_r[RES_W-1 -: 8];
            sacs_pkg::RES_LO_OFS:   rd_byte = {6'h00, res_r[1:0]};
            sacs_pkg::IRQ_STAT_OFS: rd_byte = {{(8-sacs_pkg::IRQ_W){1'b0}}, stat_r};
            sacs_pkg::IRQ_MASK_OFS: rd_byte = {{(8-sacs_pkg::IRQ_W){1'b0}}, mask_r};
            default:                rd_hit  = 1'b0;
        endcase
    end

    // One wait state per access; unmapped addresses read zero and writes drop.
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

endmodule

/* File: tb/sacs_props.sv */
// Checker for bus answers, control fields and sampling start of sacs_top.
// Assumes it is bound to sacs_top and sees only its ports.
`timescale 1ns/1ps
module sacs_props #(
    parameter int NCHAN = 8
) (
    // Clock and reset.
    input wire logic                     mclk_i,
    input wire logic                     reset_i,
    // Watched ports.
    input wire logic                     wb_cyc_i,
    input wire logic                     wb_stb_i,
    input wire logic                     wb_we_i,
    input wire logic [7:0]               wb_adr_i,
    input wire logic [3:0]               wb_sel_i,
    input wire logic [31:0]              wb_dat_i,
    input wire logic [31:0]              wb_dat_o,
    input wire logic                     wb_ack_o,
    input wire logic [$clog2(NCHAN)-1:0] mux_sel_o,
    input wire logic                     sample_o,
    input wire logic                     ref_en_o,
    input wire logic                     conv_en_o,
    input wire logic                     irq_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    logic req;
    logic wr_ctl;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ctl = req && wb_we_i && wb_sel_i[0] && wb_adr_i == sacs_pkg::CTRL_OFS;
    chk_ack_next: assert property (req |=> wb_ack_o)
        else $error("ack missing");
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ctrl_fields: assert property (wr_ctl |=> mux_sel_o == $past(wb_dat_i[2:0])
        && ref_en_o == $past(wb_dat_i[5]) && conv_en_o == $past(wb_dat_i[4]))
        else $error("control outputs wrong");
    chk_rd_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    chk_unmapped_rd: assert property (req && !wb_we_i && wb_adr_i > 8'h18
        |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    chk_mask_off: assert property (req && wb_we_i && wb_sel_i[0] && !wb_dat_i[0]
        && wb_adr_i == sacs_pkg::IRQ_MASK_OFS |=> !irq_o)
        else $error("masked interrupt high");
    chk_start_go: assert property (wr_ctl && wb_dat_i[7] && wb_dat_i[4] && !sample_o
        |-> ##[1:3] sample_o)
        else $error("sampling did not start");
    chk_start_off: assert property (wr_ctl && wb_dat_i[7] && !wb_dat_i[4] && !sample_o
        |=> !sample_o[*4])
        else $error("disabled converter sampled");
    chk_sample_en: assert property ($rose(sample_o) |-> $past(conv_en_o))
        else $error("sampling while disabled");
endmodule
bind sacs_top sacs_props #(.NCHAN(NCHAN)) u_props (
    .mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mux_sel_o(mux_sel_o), .sample_o(sample_o),
    .ref_en_o(ref_en_o), .conv_en_o(conv_en_o), .irq_o(irq_o));

/* File: tb/sacs_top_bench.sv */
// Self-checking bench for sacs_top: registers, conversions, timing, interrupt.
// Assumes the comparator compares the selected input level with dac_o.
`timescale 1ns/1ps
module sacs_top_bench;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [7:0]  pin_alt_i = 8'hDF;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        cmp_i;
    logic [2:0]  mux_sel_o;
    logic        sample_o;
    logic        ref_en_o;
    logic        conv_en_o;
    logic [9:0]  dac_o;
    logic        irq_o;
    logic [9:0]  vin [8];
    logic [31:0] exp_q [$];
    logic [31:0] rd;
    logic [7:0]  rst_v [8] = '{8'h00, 8'h0F, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic        mask = 1'b0;
    int          bad_count = 0;
    int          checked = 0;
    int          cyc = 0;
    int          run = 0;
    int          last = 0;
    int          width = 144;
    int          t0;
    int          n;

    sacs_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_i(cmp_i), .pin_alt_i(pin_alt_i),
        .mux_sel_o(mux_sel_o), .sample_o(sample_o), .ref_en_o(ref_en_o),
        .conv_en_o(conv_en_o), .dac_o(dac_o), .irq_o(irq_o));

    initial
    begin
        forever #20 mclk_i = ~mclk_i;
    end
    // Input five has no alternate function, so its comparator reads low.
    assign cmp_i = pin_alt_i[mux_sel_o] && vin[mux_sel_o] >= dac_o;

    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        run <= sample_o ? run + 1 : 0;
        if (!sample_o && run != 0)
            last <= run;
        if (wb_ack_o === 1'b1 && !wb_we_i && exp_q.size() > 0)
            cmp_data(exp_q.pop_front(), wb_dat_o);
    end

    task automatic cmp_port(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_data(input logic [31:0] e, input logic [31:0] g);
        cmp_port("read data", e, g);
    endtask
    task automatic final_report();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Ack is read before the edge's updates land, as a Wishbone master samples it.
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        do
        begin
            @(posedge mclk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        if (wb_ack_o !== 1'b1)
        begin
            bad_count++;
            final_report();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h000000, e});
        bus(a, 1'b0, 8'h00);
    endtask
    task automatic conv(input int ch);
        logic [9:0] v;
        v = pin_alt_i[ch] ? vin[ch] : 10'h000;
        t0 = cyc;
        wr(8'h00, 8'hB0 | 8'(ch));
        n = 0;
        do
        begin
            bus(8'h00, 1'b0, 8'h00);
            n++;
        end while (rd[7] !== 1'b0 && n < 200);
        if (rd[7] !== 1'b0)
        begin
            bad_count++;
            final_report();
        end
        cmp_port("convert time", 1, cyc - t0 <= sacs_pkg::CONV_MAX_CYC);
        cmp_port("sample width", width, last);
        rdx(8'h00, 8'h30 | 8'(ch));
        rdx(sacs_pkg::RES_HI_OFS, v[9:2]);
        rdx(sacs_pkg::RES_LO_OFS, {6'h00, v[1:0]});
        cmp_port("irq", {31'h0, mask}, {31'h0, irq_o});
        rdx(sacs_pkg::IRQ_STAT_OFS, 8'h01);
        wr(sacs_pkg::IRQ_STAT_OFS, 8'h01);
        rdx(sacs_pkg::IRQ_STAT_OFS, 8'h00);
        cmp_port("irq", 0, {31'h0, irq_o});
    endtask

    initial
    begin
        n = $urandom(33);
        foreach (vin[i])
            vin[i] = 10'($urandom);
        vin[0] = 10'h3FF;
        vin[7] = 10'h000;
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        wr(8'h1C, 8'hFF);
        for (int i = 0; i < 8; i++)
            rdx(8'(i * 4), rst_v[i]);
        // A write without the low byte lane selected must leave the register alone.
        wb_sel_i <= 4'hE;
        wr(sacs_pkg::SETTLE_OFS, 8'h55);
        wb_sel_i <= 4'hF;
        rdx(sacs_pkg::SETTLE_OFS, 8'h0F);
        wr(8'h00, 8'h4F);
        rdx(8'h00, 8'h07);
        wr(8'h00, 8'h81);
        rdx(8'h00, 8'h01);
        conv(2);
        mask = 1'b1;
        wr(sacs_pkg::IRQ_MASK_OFS, 8'h01);
        for (int c = 0; c < 8; c++)
            conv(c);
        vin[7] = 10'h155;
        rdx(sacs_pkg::RES_HI_OFS, 8'h00);
        width = 7;
        wr(sacs_pkg::SETTLE_OFS, 8'h02);
        wr(sacs_pkg::HOLD_OFS, 8'h03);
        conv(3);
        // Leave a finished conversion pending, then mask it off.
        wr(8'h00, 8'hB3);
        repeat (200) @(posedge mclk_i);
        cmp_port("irq", 1, {31'h0, irq_o});
        wr(sacs_pkg::IRQ_MASK_OFS, 8'h00);
        cmp_port("irq", 0, {31'h0, irq_o});
        final_report();
    end
endmodule
